// File: src/wdr_watchdog_unit.sv
// module: watchdog unit with key register, control register and reset generator
//
// Summary of operation
// R01: counter advances once every clock cycle
// R02: any reset stops; power-down stops counting
// R03: period select gives 2^(value+14) cycles
// R04: 14-bit count stage behind 7-bit prescaler
// R05: unfed time-out issues internal reset pulse
// R06: 1eh then e1h starts the watchdog
// R07: running bit reads status, ignores writes
// R08: feed pair restarts count, avoiding reset
// R09: no other register write between bytes; the checker does not police this
// R10: wrong enable or feed resets at once
// R11: 5ah then a5h gives software reset
// R12: software reset sets only soft flag
// R13: any other sequence resets, sets both flags
// R14: time-out reset sets the overflow flag
// R15: flags persist through reset; software clears
// R16: idle freeze bit holds count in idle
// R17: key write-only at a6h, control a7h
// R18: control bits: select, freeze, -, flags, running
// R19: first byte held; wrong partner is error
`default_nettype none

module wdr_watchdog_unit (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  // core status, all in the core clock domain
  input  wire logic       i_cpu_rst,
  input  wire logic       i_idle,
  input  wire logic       i_power_down,
  // special-function register bus
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  // reset request and status levels to the core
  output logic            o_wdt_rst,
  output logic            o_running_status,
  output logic            o_soft_reset_flag,
  output logic            o_overflow_reset_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  // every flip-flop sits on the one core clock; the resets, idle,
  // power-down and bus inputs come from core logic in that domain, so
  // none of them passes a synchroniser

  wdr_pkg::wdr_ctrl_t                          ctrl_q;
  wdr_pkg::wdr_ctrl_t                          ctrl_d;
  wdr_pkg::wdr_key_state_t                     key_q;
  wdr_pkg::wdr_key_state_t                     key_d;
  logic [wdr_pkg::PRESCALE_WIDTH-1:0]          presc_q;
  logic [wdr_pkg::PRESCALE_WIDTH-1:0]          presc_d;
  logic [wdr_pkg::COUNT_WIDTH-1:0]             count_q;
  logic [wdr_pkg::COUNT_WIDTH-1:0]             count_d;
  logic                                        rst_act_q;
  logic                                        rst_act_d;
  logic [2:0]                                  rst_cnt_q;
  logic [2:0]                                  rst_cnt_d;
  logic [7:0]                                  rdata_q;
  logic [7:0]                                  rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire logic key_sel;
  wire logic ctrl_sel;
  wire logic key_wr;
  wire logic ctrl_wr;
  wire logic ctrl_rd;
  wire logic any_rst;

  // every reset of the core, including our own pulse, stops the watchdog
  assign any_rst  = i_cpu_rst | rst_act_q;                              // R02
  assign key_sel  = (i_sfr_addr == wdr_pkg::WATCHDOG_KEY_ADDR);         // R17
  assign ctrl_sel = (i_sfr_addr == wdr_pkg::WATCHDOG_CONTROL_ADDR);     // R17
  // writes during the reset pulse are dropped: the core is held anyway
  assign key_wr   = i_sfr_wr & key_sel & ~any_rst;
  assign ctrl_wr  = i_sfr_wr & ctrl_sel & ~any_rst;
  // reads are not gated: the core may look at the cause flags while
  // its own reset is still being stretched
  assign ctrl_rd  = i_sfr_rd & ctrl_sel;

  ////////////////////////////////////////////////////////////////////////////
  // key byte matching

  wire logic byte_feed_first;
  wire logic byte_feed_second;
  wire logic byte_soft_first;
  wire logic byte_soft_second;

  assign byte_feed_first  = (i_sfr_wdata == wdr_pkg::KEY_FEED_FIRST);
  assign byte_feed_second = (i_sfr_wdata == wdr_pkg::KEY_FEED_SECOND);
  assign byte_soft_first  = (i_sfr_wdata == wdr_pkg::KEY_SOFT_FIRST);
  assign byte_soft_second = (i_sfr_wdata == wdr_pkg::KEY_SOFT_SECOND);

  ////////////////////////////////////////////////////////////////////////////
  // key-sequence checker
  // the checker only watches the key address; other register writes between
  // the two bytes are the caller's duty to avoid and are not policed here
  // enable and feed are the same pair: written while stopped it starts
  // the unit, written while running it restarts the count
  // a first byte that opens no pair, or a wrong partner, counts as a
  // software fault and resets at once with both cause flags set

  logic feed_ok;
  logic soft_ok;
  logic key_bad;

  // first byte is remembered until the next key write or any reset
  always_comb begin
    key_d   = key_q;
    feed_ok = 1'b0;
    soft_ok = 1'b0;
    key_bad = 1'b0;
    if (key_wr) begin
      case (key_q)
        wdr_pkg::KEY_IDLE: begin
          if (byte_feed_first) begin
            key_d = wdr_pkg::KEY_WAIT_FEED;                             // R19
          end else if (byte_soft_first) begin
            key_d = wdr_pkg::KEY_WAIT_SOFT;                             // R19
          end else begin
            key_bad = 1'b1;                                             // R13
          end
        end
        // second byte of enable or feed
        wdr_pkg::KEY_WAIT_FEED: begin
          key_d = wdr_pkg::KEY_IDLE;
          if (byte_feed_second) begin
            feed_ok = 1'b1;                                             // R06
          end else begin
            key_bad = 1'b1;                                             // R10
          end
        end
        // second byte of the software reset pair
        wdr_pkg::KEY_WAIT_SOFT: begin
          key_d = wdr_pkg::KEY_IDLE;
          if (byte_soft_second) begin
            soft_ok = 1'b1;                                             // R11
          end else begin
            key_bad = 1'b1;                                             // R19
          end
        end
        // unreachable encoding: fall back to idle
        default: begin
          key_d = wdr_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and count stage
  // the prescaler is a free 7-bit counter; the count stage steps whenever
  // the low period_select bits of the prescaler are all ones, so the whole
  // chain spans 2^(14+select) cycles from a restart
  // limitation: the separate timer prescaler that can stretch the period
  // further sits outside this block, so the longest period here is 2^21
  // cycles; an overflow during any reset is dropped, since the reset
  // already stops the unit and must not leave a stray overflow flag

  wire logic [7:0]                         presc_one;
  wire logic [wdr_pkg::PRESCALE_WIDTH-1:0] presc_mask;
  wire logic                               count_en;
  wire logic                               presc_tick;
  wire logic                               overflow;

  assign presc_one  = 8'h01 << ctrl_q.period_select;                    // R03
  assign presc_mask = 7'(presc_one - 8'h01);                            // R04
  // one step per core clock; held in power-down, and in idle when frozen
  assign count_en   = ctrl_q.running_status & ~i_power_down             // R02
                    & ~(i_idle & ctrl_q.idle_freeze);                   // R16
  assign presc_tick = count_en & ((presc_q & presc_mask) == presc_mask); // R04
  assign overflow   = presc_tick & (count_q == wdr_pkg::COUNT_LAST)     // R05
                    & ~feed_ok & ~any_rst;

  // a feed in the same cycle as the last step wins: software was in time
  always_comb begin
    presc_d = presc_q;
    count_d = count_q;
    if (any_rst || feed_ok || overflow) begin
      presc_d = wdr_pkg::PRESCALE_RESET;                                // R08
      count_d = wdr_pkg::COUNT_RESET;
    end else if (count_en) begin
      presc_d = presc_q + 7'h01;                                        // R01
      if (presc_tick) begin
        count_d = count_q + 14'h0001;                                   // R04
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal reset pulse generator
  // a new trigger is blocked while any reset is active, so a late event
  // can neither stretch nor restart the pulse, and the counter always
  // runs its full length

  wire logic rst_trigger;

  assign rst_trigger = ~any_rst & (overflow | soft_ok | key_bad);       // R05

  // a fixed-length pulse, so the core sees a clean reset of known width
  always_comb begin
    rst_act_d = rst_act_q;
    rst_cnt_d = rst_cnt_q;
    if (rst_trigger) begin
      rst_act_d = 1'b1;                                                 // R10
      rst_cnt_d = wdr_pkg::RST_PULSE_CYC - 3'h1;
    end else if (rst_act_q) begin
      if (rst_cnt_q == 3'h0) begin
        rst_act_d = 1'b0;
      end else begin
        rst_cnt_d = rst_cnt_q - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register next value
  // setup fields return to zero on any reset, since the unit must be
  // enabled again afterwards; the flags do not, so software can read
  // the cause once the core runs again

  wire logic soft_set;
  wire logic ovf_set;
  wire logic soft_clr;
  wire logic ovf_clr;

  assign soft_set = soft_ok | key_bad;                                  // R12
  assign ovf_set  = overflow | key_bad;                                 // R14
  // software clears a flag by writing 0 to it; a write of 1 leaves it
  assign soft_clr = ctrl_wr & ~i_sfr_wdata[wdr_pkg::SOFT_RESET_BIT];    // R15
  assign ovf_clr  = ctrl_wr & ~i_sfr_wdata[wdr_pkg::OVERFLOW_BIT];      // R15

  // both cause flags share one shape: set by their event, cleared when
  // software writes 0 to their bit, kept through every reset but power-on;
  // a set in the cycle of a clear wins, so no reset cause is ever lost
  // bit 1 carries the soft-reset flag, bit 0 the overflow flag

  wire logic [1:0] flag_q;
  wire logic [1:0] flag_set;
  wire logic [1:0] flag_clr;
  wire logic [1:0] flag_d;

  // gather the per-flag terms
  assign flag_q   = {ctrl_q.soft_reset_flag, ctrl_q.overflow_reset_flag};
  assign flag_set = {soft_set, ovf_set};                                // R14
  assign flag_clr = {soft_clr, ovf_clr};                                // R15

  // one set/clear cell per flag
  for (genvar f = 0; f < 2; f++) begin : g_flag
    assign flag_d[f] = (flag_q[f] & ~flag_clr[f]) | flag_set[f];        // R15
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (any_rst) begin
      // reset clears setup and stops the unit but keeps the cause flags
      ctrl_d.period_select  = 3'h0;                                     // R02
      ctrl_d.idle_freeze    = 1'b0;
      ctrl_d.running_status = 1'b0;                                     // R02
    end else begin
      if (ctrl_wr) begin
        ctrl_d.period_select =
          i_sfr_wdata[wdr_pkg::PERIOD_SELECT_MSB:wdr_pkg::PERIOD_SELECT_LSB]; // R18
        ctrl_d.idle_freeze   = i_sfr_wdata[wdr_pkg::IDLE_FREEZE_BIT];  // R16
      end
      // running bit follows the key sequence only, never a write
      if (feed_ok) begin
        ctrl_d.running_status = 1'b1;                                   // R07
      end
    end
    ctrl_d.unused = 1'b0;
    // cause flags come from their set/clear cells
    ctrl_d.soft_reset_flag     = flag_d[1];                             // R12
    ctrl_d.overflow_reset_flag = flag_d[0];                             // R13
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  // only the control register answers; the key register reads as zero,
  // as does every other address, since it holds nothing to show

  assign rdata_d = ctrl_rd ? ctrl_q : 8'h00;                           // R17

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // only the power-on reset clears these flip-flops; the core reset and
  // our own pulse act through the next-value logic above, which is what
  // lets the cause flags survive them

  // control register and key checker
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= wdr_pkg::WATCHDOG_CONTROL_RESET;
      key_q  <= wdr_pkg::KEY_IDLE;
    end else begin
      ctrl_q <= ctrl_d;
      key_q  <= any_rst ? wdr_pkg::KEY_IDLE : key_d;                   // R02
    end
  end

  // prescaler and count stage
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      presc_q <= wdr_pkg::PRESCALE_RESET;
      count_q <= wdr_pkg::COUNT_RESET;
    end else begin
      presc_q <= presc_d;
      count_q <= count_d;
    end
  end

  // reset pulse generator and read data
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rst_act_q <= 1'b0;
      rst_cnt_q <= 3'h0;
      rdata_q   <= 8'h00;
    end else begin
      rst_act_q <= rst_act_d;
      rst_cnt_q <= rst_cnt_d;
      rdata_q   <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  // the flags and running bit also leave as levels, so the reset logic
  // can tell a software fault from a deliberate software reset

  assign o_sfr_rdata           = rdata_q;
  assign o_wdt_rst             = rst_act_q;                             // R05
  assign o_running_status      = ctrl_q.running_status;
  assign o_soft_reset_flag     = ctrl_q.soft_reset_flag;
  assign o_overflow_reset_flag = ctrl_q.overflow_reset_flag;

endmodule

`default_nettype wire

// File: src/wdr_pkg.sv
// package: register map, field layout and timing constants of the watchdog unit
`default_nettype none

package wdr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // special-function addresses
  localparam logic [7:0] WATCHDOG_KEY_ADDR     = 8'ha6;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'ha7;

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int PERIOD_SELECT_MSB = 7;
  localparam int PERIOD_SELECT_LSB = 5;
  localparam int IDLE_FREEZE_BIT   = 4;
  localparam int UNUSED_BIT        = 3;
  localparam int SOFT_RESET_BIT    = 2;
  localparam int OVERFLOW_BIT      = 1;
  localparam int RUNNING_BIT       = 0;

  // reset value of the control register (flags survive the reset they record)
  localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // key bytes
  localparam logic [7:0] KEY_FEED_FIRST  = 8'h1e;
  localparam logic [7:0] KEY_FEED_SECOND = 8'he1;
  localparam logic [7:0] KEY_SOFT_FIRST  = 8'h5a;
  localparam logic [7:0] KEY_SOFT_SECOND = 8'ha5;

  ////////////////////////////////////////////////////////////////////////////
  // counter widths and timing
  localparam int COUNT_WIDTH     = 14;
  localparam int PRESCALE_WIDTH  = 7;
  localparam logic [COUNT_WIDTH-1:0]    COUNT_RESET    = 14'h0000;
  localparam logic [COUNT_WIDTH-1:0]    COUNT_LAST     = 14'h3fff;
  localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 7'h00;
  // length of the internal reset pulse, in clock cycles
  localparam logic [2:0] RST_PULSE_CYC  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // control register image, bit 7 first
  typedef struct packed {
    logic [2:0] period_select;
    logic       idle_freeze;
    logic       unused;
    logic       soft_reset_flag;
    logic       overflow_reset_flag;
    logic       running_status;
  } wdr_ctrl_t;

  // key-sequence checker states
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_WAIT_FEED,
    KEY_WAIT_SOFT
  } wdr_key_state_t;

endpackage

`default_nettype wire

// File: sim/wdr_checker.sv
// checker: port-level assertions for the watchdog unit
`default_nettype none
module wdr_checker (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_cpu_rst,
  input wire logic       i_idle,
  input wire logic       i_power_down,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_wdt_rst,
  input wire logic       o_running_status,
  input wire logic       o_soft_reset_flag,
  input wire logic       o_overflow_reset_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // write decode; writes are dropped while any reset is active
  wire logic       blk = i_cpu_rst || o_wdt_rst;
  wire logic       kw  = i_sfr_wr && !blk && i_sfr_addr == wdr_pkg::WATCHDOG_KEY_ADDR;
  wire logic       cw  = i_sfr_wr && !blk && i_sfr_addr == wdr_pkg::WATCHDOG_CONTROL_ADDR;
  wire logic [7:0] d   = i_sfr_wdata;
  wire logic       bad = kw && !(d inside {8'h1e, 8'he1, 8'h5a, 8'ha5});
  wire logic       krd = i_sfr_rd && i_sfr_addr == wdr_pkg::WATCHDOG_KEY_ADDR;
  wire logic       crd = i_sfr_rd && i_sfr_addr == wdr_pkg::WATCHDOG_CONTROL_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // one domain, so clock and disable are given once
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_pulse; $rose(o_wdt_rst) |-> o_wdt_rst[*4] ##1 !o_wdt_rst; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
  property p_bad; bad |=> o_wdt_rst && o_soft_reset_flag && o_overflow_reset_flag; endproperty
  a_bad: assert property (p_bad) else $error("bad key byte not punished");
  property p_stop; $rose(o_wdt_rst) |=> !o_running_status; endproperty
  a_stop: assert property (p_stop) else $error("still running after reset");
  property p_core; i_cpu_rst |=> !o_running_status; endproperty
  a_core: assert property (p_core) else $error("core reset did not stop unit");
  property p_start; $rose(o_running_status) |-> $past(kw && d == 8'he1); endproperty
  a_start: assert property (p_start) else $error("start without key pair");
  property p_sflag; $fell(o_soft_reset_flag) |-> $past(cw && !d[2]); endproperty
  a_sflag: assert property (p_sflag) else $error("soft flag lost");
  property p_oflag; $fell(o_overflow_reset_flag) |-> $past(cw && !d[1]); endproperty
  a_oflag: assert property (p_oflag) else $error("overflow flag lost");
  property p_oset; $rose(o_overflow_reset_flag) |-> o_wdt_rst; endproperty
  a_oset: assert property (p_oset) else $error("overflow flag without reset");
  property p_noread; !i_sfr_rd |=> o_sfr_rdata == 8'h00; endproperty
  a_noread: assert property (p_noread) else $error("read data without read");
  property p_keyrd; krd |=> o_sfr_rdata == 8'h00; endproperty
  a_keyrd: assert property (p_keyrd) else $error("key register readable");
  property p_rsv; crd |=> !o_sfr_rdata[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("unused control bit set");
endmodule
`default_nettype wire

// File: sim/testbench.sv
// testbench: self-checking bench for the watchdog unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] KA = wdr_pkg::WATCHDOG_KEY_ADDR;
  localparam logic [7:0] CA = wdr_pkg::WATCHDOG_CONTROL_ADDR;
  logic       clk, srst, crst, idle, pd, we, re, wrst, run, sf, of;
  logic [7:0] addr, wd, rdata, rb;
  logic [15:0] bad [4];
  int         err_total, check_count, seed, m_ctrl, n, r;

  ////////////////////////////////////////////////////////////////////////////
  // device under test
  wdr_watchdog_unit u_wdr_watchdog_unit (
    .i_core_clk(clk), .i_sys_rst(srst), .i_cpu_rst(crst), .i_idle(idle),
    .i_power_down(pd), .i_sfr_addr(addr), .i_sfr_wr(we), .i_sfr_wdata(wd),
    .i_sfr_rd(re), .o_sfr_rdata(rdata), .o_wdt_rst(wrst), .o_running_status(run),
    .o_soft_reset_flag(sf), .o_overflow_reset_flag(of));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // bus tasks, entered at a falling edge; the idle cycle avoids double drives
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    addr = a;
    wd = dv;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    check(nm, exp, rdata);
    @(negedge clk);
  endtask

  task automatic key(input logic [7:0] a, input logic [7:0] b);
    wr(KA, a);
    wr(KA, b);
  endtask

  // model of a control write: flags only clear, running bit read-only
  function automatic int cw(input int v);
    return (v & 'hf0) | (m_ctrl & v & 6) | (m_ctrl & 1);
  endfunction

  task automatic wcon(input int v);
    m_ctrl = cw(v);
    wr(CA, 8'(v));
  endtask

  // a reset clears select, freeze and running but keeps flags, then ors in cause
  task automatic cause(input int f);
    m_ctrl = (m_ctrl & 6) | f;
    check("pulse", 1, wrst);
    check("sflag", 8'(f >> 2), sf);
    check("oflag", 8'((f >> 1) & 1), of);
    repeat (6) @(negedge clk);
    rdc(CA, 8'(m_ctrl), "ctl_after");
  endtask

  task automatic wait_rst(input int lim);
    n = 0;
    while (wrst !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog on the run itself
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    $display("run exceeded its time limit");
    print_verdict;
  end

  // main sequence
  initial begin
    seed = 32'hf84e4acd;
    {srst, crst, idle, pd, we, re, addr, wd} = {1'b1, 5'h00, 16'h0000};
    m_ctrl = 0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    rdc(CA, 8'h00, "ctl_reset");
    rdc(KA, 8'h00, "key_read");
    key(8'h1e, 8'he1);
    m_ctrl |= 1;
    check("enable", 1, run);
    repeat (4) begin
      r = $random(seed);
      wcon(r);
      rdc(CA, 8'(m_ctrl), "ctl_rand");
      rb = 8'($random(seed));
      if (rb[7:1] == 7'h53) rb = 8'h00;
      wr(rb, 8'($random(seed)));
      rdc(rb, 8'h00, "unmapped");
    end
    $display("test registers done");
    repeat (2) begin
      key(8'h5a, 8'ha5);
      cause(4);
    end
    $display("test software reset done");
    rb = 8'($random(seed));
    if (rb == 8'h1e || rb == 8'h5a) rb = 8'h33;
    bad = '{16'h1e55, 16'h5ae1, 16'h1ea5, {rb, 8'h00}};
    foreach (bad[i]) begin
      wcon(0);
      wr(KA, bad[i][15:8]);
      if (bad[i][7:0] != 8'h00) wr(KA, bad[i][7:0]);
      cause(6);
    end
    key(8'h1e, 8'he1);
    crst = 1'b1;
    @(negedge clk);
    crst = 1'b0;
    m_ctrl &= 6;
    rdc(CA, 8'(m_ctrl), "core_rst");
    wcon(1);
    rdc(CA, 8'h00, "flag_clr");
    $display("test sequences done");
    key(8'h1e, 8'he1);
    idle = 1'b1;
    repeat (10000) @(negedge clk);
    idle = 1'b0;
    check("early", 0, wrst);
    key(8'h1e, 8'he1);
    wait_rst(20000);
    check("period0", 1, 8'(n > 16376 && n < 16390));
    cause(2);
    wcon('h30);
    key(8'h1e, 8'he1);
    idle = 1'b1;
    repeat (1000) @(negedge clk);
    idle = 1'b0;
    pd = 1'b1;
    repeat (1000) @(negedge clk);
    pd = 1'b0;
    wait_rst(40000);
    check("period1", 1, 8'(n > 32760 && n < 32774));
    cause(2);
    $display("test time-out done");
    print_verdict;
  end
endmodule

bind wdr_watchdog_unit wdr_checker u_wdr_checker (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cpu_rst(i_cpu_rst),
  .i_idle(i_idle), .i_power_down(i_power_down), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
  .o_sfr_rdata(o_sfr_rdata), .o_wdt_rst(o_wdt_rst), .o_running_status(o_running_status),
  .o_soft_reset_flag(o_soft_reset_flag), .o_overflow_reset_flag(o_overflow_reset_flag));
`default_nettype wire
